// *** include/scsi_setup_cfg.svh ***
`ifndef SCSI_SETUP_CFG_SVH
`define SCSI_SETUP_CFG_SVH
// register word addresses (byte address bits [6:2])
`define ADR_CMDLEN      5'h1A
`define ADR_PARITY      5'h19
`define ADR_INTMASK     5'h1B
`define ADR_DMAMODE     5'h1C
`define ADR_CONTROL     5'h1E
`define ADR_STATUS      5'h1F
// parity_config bits
`define PAR_SCSI_CHK    7
`define PAR_SCSI_GEN    6
`define PAR_ODD         5
`define PAR_MPU_CHK     4
`define PAR_MPU_GEN     3
`define PAR_DMA_CHK     1
`define PAR_DMA_GEN     0
// interrupt_group_mask
`define INT_MASTER      7
`define INT_GROUPS      6
// dma_mode_config
`define DMA_WIDE        5
`define DMA_BURST       4
// control register: write 1 applies parity setup
`define CTL_APPLY       0
`define RST_BYTE        8'h00
`endif

// *** include/scsi_setup_pkg.sv ***
`default_nettype none
package scsi_setup_pkg;
   typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_WAIT_RELEASE} dma_state_t;
   typedef enum logic [1:0] {PH_OTHER, PH_DATA, PH_MSG_STATUS_CMD} scsi_phase_t;
   typedef enum logic [1:0] {PORT_SCSI, PORT_MPU_REG, PORT_MPU_DATA, PORT_DMA} parity_port_t;
endpackage : scsi_setup_pkg
`default_nettype wire

// *** include/parity_if.sv ***
`default_nettype none
interface parity_if;
   logic [7:0] parCfg;
   logic       applied;
   logic       extAccess;
   logic       initiator;
   logic       phaseData;
   logic       phaseCtl;
   logic       dirIn;
   logic       mpuRegWrite;
   logic       mpuRegRead;
   logic       mpuDataAccess;
   logic       dmaAccess;
   logic       scsiChk;
   logic       scsiGen;
   logic       mpuChk;
   logic       mpuGen;
   logic       dmaChk;
   logic       dmaGen;
   logic       oddParity;
   modport ctrl (output parCfg, applied, extAccess, initiator, phaseData, phaseCtl, dirIn,
                 output mpuRegWrite, mpuRegRead, mpuDataAccess, dmaAccess,
                 input scsiChk, scsiGen, mpuChk, mpuGen, dmaChk, dmaGen, oddParity);
   modport dec  (input parCfg, applied, extAccess, initiator, phaseData, phaseCtl, dirIn,
                 input mpuRegWrite, mpuRegRead, mpuDataAccess, dmaAccess,
                 output scsiChk, scsiGen, mpuChk, mpuGen, dmaChk, dmaGen, oddParity);
endinterface : parity_if
`default_nettype wire

// *** rtl/parity_decode.sv ***
`include "scsi_setup_cfg.svh"
`default_nettype none
// pure decode of the applied parity setup into per-path enables
module parity_decode (
   parity_if.dec p
);
   logic live;
   always_comb begin
      // external bus cycles never check or generate
      live = p.applied && !p.extAccess;
      // scsi check: any data phase either way; msg/status/cmd only on input
      p.scsiChk = live && p.parCfg[`PAR_SCSI_CHK] &&
                  (p.phaseData || (p.phaseCtl && p.dirIn));
      p.scsiGen = live && p.parCfg[`PAR_SCSI_GEN] && p.phaseData;
      p.oddParity = p.parCfg[`PAR_ODD];
      p.mpuChk = live && p.parCfg[`PAR_MPU_CHK] &&
                 (p.mpuRegWrite || (p.mpuDataAccess && p.phaseData));
      // non-data register reads carry parity whenever live, register writes never
      p.mpuGen = live && ((p.mpuRegRead && !p.mpuDataAccess) ||
                 (p.parCfg[`PAR_MPU_GEN] && p.mpuDataAccess && p.phaseData));
      p.dmaChk = live && p.parCfg[`PAR_DMA_CHK] && p.dmaAccess && p.phaseData;
      p.dmaGen = live && p.parCfg[`PAR_DMA_GEN] && p.dmaAccess && p.phaseData;
   end
endmodule : parity_decode
`default_nettype wire

// *** rtl/scsi_setup_regs.sv ***
// Chosen here: register access over Wishbone.
`include "scsi_setup_cfg.svh"
`default_nettype none
// Behaviour
// - no parity checking until parity setup is loaded and the apply command issued
// - parity generation enables act only during the scsi data phase, except processor generate on ordinary register reads
// - scsi check bit: check msg-in/status/cmd/msg-out input and data either direction
// - scsi generate bit: generate parity for data-phase bytes only
// - system parity type: one odd, zero even, for processor and dma buses
// - processor check: all register writes, and data-register access in data phase
// - processor generate: data-register access in program-transfer data phase
// - never generate on register writes; once the setup is applied, generate on every ordinary register read
// - dma check bit: check dma bus data both ways during dma data phase
// - dma generate bit: generate dma bus parity during dma data phase
// - no parity check or generate during external bus accesses
// - master enable clear masks all causes; set lets each group bit gate
// - top three interrupt code bits pick group enable bits zero to five
// - codes always recorded in status even when masked
// - low nibble: group 6 length, twice value in bytes, zero unspecified
// - high nibble: group 7 length, twice value in bytes, zero unspecified
// - dma width bit: one 16-bit, zero 8-bit
// - burst mode holds request while transfer possible; else handshake per word
// - to dma: data presented, then request, dropped on acknowledge (the code drives data and request in the same cycle)
// - from dma: request first, dropped on acknowledge, data taken then
// - next request waits until acknowledge is released
module scsi_setup_regs (
   input  wire  logic        clock,
   input  wire  logic        sys_rst,
   input  wire  logic        clkEn,
   // wishbone classic slave
   input  wire  logic        wbCyc,
   input  wire  logic        wbStb,
   input  wire  logic        wbWe,
   input  wire  logic [6:0]  wbAdr,
   input  wire  logic [3:0]  wbSel,
   input  wire  logic [31:0] wbDatW,
   output logic        [31:0] wbDatR,
   output logic              wbAck,
   // protocol-side context
   input  wire  logic        extAccess,
   input  wire  logic        initiator,
   input  wire  logic        phaseData,
   input  wire  logic        phaseCtl,
   input  wire  logic        dirIn,
   input  wire  logic        mpuRegWrite,
   input  wire  logic        mpuRegRead,
   input  wire  logic        mpuDataAccess,
   input  wire  logic        dmaAccess,
   // interrupt codes from the sequencer
   input  wire  logic        intCodeValid,
   input  wire  logic [7:0]  intCode,
   // dma data path
   input  wire  logic        xferPossible,
   input  wire  logic        toDma,
   input  wire  logic [15:0] txData,
   input  wire  logic [15:0] dmaDataIn,
   input  wire  logic        transfer_grant_in,
   output logic              transfer_request_out,
   output logic        [15:0] dmaDataOut,
   output logic              dmaDataOe,
   output logic        [15:0] rxData,
   output logic              rxValid,
   output logic              intOut,
   output logic              scsiChkEn,
   output logic              scsiGenEn,
   output logic              mpuChkEn,
   output logic              mpuGenEn,
   output logic              dmaChkEn,
   output logic              dmaGenEn,
   output logic              oddParity,
   output logic        [4:0] group6Bytes,
   output logic        [4:0] group7Bytes,
   output logic              dmaWide
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]                cmdLen;
      logic [7:0]                parCfg;
      logic [7:0]                parApplied;
      logic                      applied;
      logic [7:0]                intMask;
      logic [7:0]                dmaCfg;
      logic [7:0]                intStatus;
      logic                      intPend;
      scsi_setup_pkg::dma_state_t dma;
      logic                      ack;
      logic [31:0]               rdata;
      logic                      req;
      logic [15:0]               dout;
      logic                      doe;
      logic [15:0]               rx;
      logic                      rxv;
      logic                      irq;
      logic [6:0]                parOut;
      logic [4:0]                g6;
      logic [4:0]                g7;
      logic                      wide;
   } state_t;

   state_t s_q;
   state_t s_d;
   parity_if par ();

   assign par.parCfg        = s_q.parApplied;
   assign par.applied       = s_q.applied;
   assign par.extAccess     = extAccess;
   assign par.initiator     = initiator;
   assign par.phaseData     = phaseData;
   assign par.phaseCtl      = phaseCtl;
   assign par.dirIn         = dirIn;
   assign par.mpuRegWrite   = mpuRegWrite;
   assign par.mpuRegRead    = mpuRegRead;
   assign par.mpuDataAccess = mpuDataAccess;
   assign par.dmaAccess     = dmaAccess;

   parity_decode u_dec (
      .p (par.dec)
   );

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   logic       req;
   logic [4:0] adr;
   logic [2:0] grp;
   logic       grpOn;
   logic [7:0] wbyte;

   always_comb begin
      s_d   = s_q;
      adr   = wbAdr[6:2];
      wbyte = wbDatW[7:0];
      req   = wbCyc && wbStb && !s_q.ack;
      s_d.ack = req;

      // single-cycle ack; byte lane 0 holds all data
      if (req) begin
         s_d.rdata = 32'h0000_0000;
         case (adr)
            `ADR_CMDLEN:  s_d.rdata[7:0] = s_q.cmdLen;
            `ADR_PARITY:  s_d.rdata[7:0] = s_q.parCfg;
            `ADR_INTMASK: s_d.rdata[7:0] = s_q.intMask;
            `ADR_DMAMODE: s_d.rdata[7:0] = s_q.dmaCfg;
            `ADR_CONTROL: s_d.rdata[0]   = s_q.applied;
            `ADR_STATUS:  s_d.rdata[7:0] = s_q.intStatus;
            default:      s_d.rdata      = 32'h0000_0000;
         endcase
         if (wbWe && wbSel[0]) begin
            case (adr)
               `ADR_CMDLEN:  s_d.cmdLen  = wbyte;
               // new setup waits for the apply command
               `ADR_PARITY:  s_d.parCfg  = wbyte;
               `ADR_INTMASK: s_d.intMask = wbyte;
               `ADR_DMAMODE: s_d.dmaCfg  = wbyte;
               `ADR_CONTROL: begin
                  if (wbyte[`CTL_APPLY]) begin
                     s_d.parApplied = s_q.parCfg;
                     s_d.applied    = 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end

      // status read pops the pending code; a new code wins over the pop
      if (req && !wbWe && adr == `ADR_STATUS) begin
         s_d.intPend = 1'b0;
      end
      if (intCodeValid) begin
         s_d.intStatus = intCode;
         s_d.intPend   = 1'b1;
      end

      // interrupt gating from the current pending code
      grp   = s_q.intStatus[7:5];
      grpOn = (grp < 3'(`INT_GROUPS)) ? s_q.intMask[grp] : 1'b0;
      s_d.irq = s_q.intPend && s_q.intMask[`INT_MASTER] && grpOn;

      s_d.g6   = {s_q.cmdLen[3:0], 1'b0};
      s_d.g7   = {s_q.cmdLen[7:4], 1'b0};
      s_d.wide = s_q.dmaCfg[`DMA_WIDE];

      s_d.parOut = {par.scsiChk, par.scsiGen, par.mpuChk, par.mpuGen,
                    par.dmaChk, par.dmaGen, par.oddParity};

      // dma request/grant
      s_d.rxv = 1'b0;
      if (s_q.dmaCfg[`DMA_BURST]) begin
         // burst: request held while the core can move data
         s_d.req = xferPossible;
         s_d.doe = xferPossible && toDma;
         s_d.dout = txData;
         if (transfer_grant_in && !toDma) begin
            s_d.rx  = dmaDataIn;
            s_d.rxv = 1'b1;
         end
         s_d.dma = scsi_setup_pkg::DMA_IDLE;
      end else begin
         case (s_q.dma)
            scsi_setup_pkg::DMA_IDLE: begin
               s_d.req = 1'b0;
               if (xferPossible && !transfer_grant_in) begin
                  // outbound data is on the bus with the request edge
                  s_d.dout = txData;
                  s_d.doe  = toDma;
                  s_d.req  = 1'b1;
                  s_d.dma  = scsi_setup_pkg::DMA_REQ;
               end
            end
            scsi_setup_pkg::DMA_REQ: begin
               if (transfer_grant_in) begin
                  s_d.req = 1'b0;
                  if (!toDma) begin
                     s_d.rx  = dmaDataIn;
                     s_d.rxv = 1'b1;
                  end
                  s_d.dma = scsi_setup_pkg::DMA_WAIT_RELEASE;
               end
            end
            scsi_setup_pkg::DMA_WAIT_RELEASE: begin
               s_d.doe = 1'b0;
               if (!transfer_grant_in) begin
                  s_d.dma = scsi_setup_pkg::DMA_IDLE;
               end
            end
            default: s_d.dma = scsi_setup_pkg::DMA_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_q <= '0;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign wbAck                = s_q.ack;
   assign wbDatR               = s_q.rdata;
   assign transfer_request_out = s_q.req;
   assign dmaDataOut           = s_q.dout;
   assign dmaDataOe            = s_q.doe;
   assign rxData               = s_q.rx;
   assign rxValid              = s_q.rxv;
   assign intOut               = s_q.irq;
   assign scsiChkEn            = s_q.parOut[6];
   assign scsiGenEn            = s_q.parOut[5];
   assign mpuChkEn             = s_q.parOut[4];
   assign mpuGenEn             = s_q.parOut[3];
   assign dmaChkEn             = s_q.parOut[2];
   assign dmaGenEn             = s_q.parOut[1];
   assign oddParity            = s_q.parOut[0];
   assign group6Bytes          = s_q.g6;
   assign group7Bytes          = s_q.g7;
   assign dmaWide              = s_q.wide;
endmodule : scsi_setup_regs
`default_nettype wire

// *** dv/scsi_setup_regs_properties.sv ***
`include "scsi_setup_cfg.svh"
`default_nettype none
module scsi_setup_regs_properties (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        wbCyc,
   input wire logic        wbStb,
   input wire logic        wbWe,
   input wire logic [6:0]  wbAdr,
   input wire logic [3:0]  wbSel,
   input wire logic [31:0] wbDatW,
   input wire logic [31:0] wbDatR,
   input wire logic        wbAck,
   input wire logic        extAccess,
   input wire logic        phaseData,
   input wire logic        xferPossible,
   input wire logic        transfer_grant_in,
   input wire logic        transfer_request_out,
   input wire logic        intOut,
   input wire logic        scsiChkEn,
   input wire logic        scsiGenEn,
   input wire logic        mpuChkEn,
   input wire logic        mpuGenEn,
   input wire logic        dmaChkEn,
   input wire logic        dmaGenEn,
   input wire logic [4:0]  group6Bytes,
   input wire logic [4:0]  group7Bytes
);
   timeunit 1ns;
   timeprecision 1ns;
   logic burst_q;
   logic master_q;
   logic applied_q;
   logic take;
   // mirrors of mode, master and apply bits, updated at the taking edge like the slave
   assign take = wbCyc && wbStb && wbWe && !wbAck && wbSel[0];
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         burst_q   <= 1'b0;
         master_q  <= 1'b0;
         applied_q <= 1'b0;
      end else if (take) begin
         if (wbAdr[6:2] == `ADR_DMAMODE) burst_q <= wbDatW[`DMA_BURST];
         if (wbAdr[6:2] == `ADR_INTMASK) master_q <= wbDatW[`INT_MASTER];
         if (wbAdr[6:2] == `ADR_CONTROL && wbDatW[`CTL_APPLY]) applied_q <= 1'b1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
   a_ack_answer: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("request not answered");
   a_len_double: assert property (wbAck && !wbWe && wbAdr[6:2] == `ADR_CMDLEN |->
      group6Bytes == {wbDatR[3:0], 1'b0} && group7Bytes == {wbDatR[7:4], 1'b0}) else $error("length not doubled");
   a_check_held: assert property (!applied_q |-> !(scsiChkEn || mpuChkEn || dmaChkEn))
      else $error("check before apply");
   a_ext_silent: assert property ($past(extAccess) |->
      !(scsiChkEn || scsiGenEn || mpuChkEn || mpuGenEn || dmaChkEn || dmaGenEn)) else $error("parity in ext access");
   a_gen_data: assert property (scsiGenEn |-> $past(phaseData)) else $error("scsi gen outside data");
   a_int_master: assert property (intOut |-> $past(master_q)) else $error("interrupt with master off");
   a_req_drop: assert property (!burst_q && transfer_request_out && transfer_grant_in |=>
      !transfer_request_out) else $error("request kept after grant");
   a_req_wait: assert property (!burst_q && $rose(transfer_request_out) |-> !$past(transfer_grant_in))
      else $error("request while grant high");
   a_burst_follow: assert property (burst_q && $past(burst_q) |->
      transfer_request_out == $past(xferPossible)) else $error("burst request wrong");
endmodule : scsi_setup_regs_properties
`default_nettype wire

// *** dv/dma_partner.sv ***
`default_nettype none
module dma_partner (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        en,
   input  wire logic        req,
   input  wire logic        toDma,
   input  wire logic [15:0] dout,
   input  wire logic [15:0] inWord,
   input  wire logic [1:0]  lag,
   output var  logic        grant,
   output logic      [15:0] din,
   output var  logic        capV,
   output var  logic [15:0] capD
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_q;
   // released bus shows the inverse so a stale word never passes
   assign din = (grant && !toDma) ? inWord : ~inWord;
   always @(posedge clock) begin
      capV <= 1'b0;
      if (sys_rst) begin
         grant  <= 1'b0;
         wait_q <= '0;
      end else if (grant) begin
         if (!req) grant <= 1'b0;
      end else if (req && en) begin
         if (wait_q == lag) begin
            grant  <= 1'b1;
            capV   <= toDma;
            capD   <= dout;
            wait_q <= '0;
         end else wait_q <= wait_q + 2'h1;
      end
   end
endmodule : dma_partner
`default_nettype wire

// *** dv/scsi_setup_regs_test.sv ***
`include "scsi_setup_cfg.svh"
`default_nettype none
module scsi_setup_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = '0, sys_rst = '1, clkEn = '1, wbCyc = '0, wbStb = '0, wbWe = '0;
   logic [6:0]  wbAdr = '0;
   logic [3:0]  wbSel = '0;
   logic [31:0] wbDatW = '0, wbDatR;
   logic        wbAck, extAccess = '0, initiator = '0, phaseData = '0, phaseCtl = '0, dirIn = '0;
   logic        mpuRegWrite = '0, mpuRegRead = '0, mpuDataAccess = '0, dmaAccess = '0, intCodeValid = '0;
   logic [7:0]  intCode = '0;
   logic        xferPossible = '0, toDma = '0, partEn = '0, transfer_grant_in, transfer_request_out;
   logic        dmaDataOe, rxValid, intOut, capV, dmaWide, oddParity;
   logic        scsiChkEn, scsiGenEn, mpuChkEn, mpuGenEn, dmaChkEn, dmaGenEn;
   logic [15:0] txData = '0, inWord = '0, dmaDataIn, dmaDataOut, rxData, capD;
   logic [4:0]  group6Bytes, group7Bytes;
   logic [1:0]  lag = '0;
   logic [5:0]  parEn;
   assign parEn = {scsiChkEn, scsiGenEn, mpuChkEn, mpuGenEn, dmaChkEn, dmaGenEn};
   int          mismatches = 0, compares = 0, seed = 36;
   logic [31:0] rq[$];
   logic [15:0] dq[$];
   localparam logic [6:0] aLen = {`ADR_CMDLEN, 2'h0}, aPar = {`ADR_PARITY, 2'h0}, aMask = {`ADR_INTMASK, 2'h0};
   localparam logic [6:0] aDma = {`ADR_DMAMODE, 2'h0}, aCtl = {`ADR_CONTROL, 2'h0}, aStat = {`ADR_STATUS, 2'h0};
   localparam logic [6:0] aFree = 7'h10;
   scsi_setup_regs scsi_setup_regs_i (.clock, .sys_rst, .clkEn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW,
      .wbDatR, .wbAck, .extAccess, .initiator, .phaseData, .phaseCtl, .dirIn, .mpuRegWrite, .mpuRegRead,
      .mpuDataAccess, .dmaAccess, .intCodeValid, .intCode, .xferPossible, .toDma, .txData, .dmaDataIn,
      .transfer_grant_in, .transfer_request_out, .dmaDataOut, .dmaDataOe, .rxData, .rxValid, .intOut, .scsiChkEn,
      .scsiGenEn, .mpuChkEn, .mpuGenEn, .dmaChkEn, .dmaGenEn, .oddParity, .group6Bytes, .group7Bytes, .dmaWide);
   dma_partner dma_partner_i (.clock, .sys_rst, .en(partEn), .req(transfer_request_out), .toDma, .dout(dmaDataOut),
      .inWord, .lag, .grant(transfer_grant_in), .din(dmaDataIn), .capV, .capD);
   always #25 clock = ~clock;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wrap_up;
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   task automatic hang;
      mismatches++;
      $display("ERROR %0t no answer", $time);
      wrap_up();
   endtask : hang
   task automatic wb(input logic w, input logic [6:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      {wbCyc, wbStb, wbWe, wbSel} <= {2'h3, w, 4'hF};
      {wbAdr, wbDatW} <= {a, d};
      n = 0;
      do begin @(posedge clock); n++; end while (wbAck !== 1'b1 && n < 20);
      if (wbAck !== 1'b1) hang();
      {wbCyc, wbStb} <= 2'h0;
   endtask : wb
   task automatic rd(input logic [6:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(1'b0, a, '0);
   endtask : rd
   task automatic dmaWord(input logic dir);
      logic [15:0] w;
      int n;
      w = 16'($random(seed));
      dq.push_back(w);
      @(posedge clock);
      {lag, toDma, xferPossible} <= {2'($random(seed)), dir, 1'b1};
      if (dir) txData <= w;
      else inWord <= w;
      n = 0;
      do begin @(posedge clock); n++; end while ((dir ? capV : rxValid) !== 1'b1 && n < 40);
      if (n >= 40) hang();
      xferPossible <= 1'b0;
   endtask : dmaWord
   function automatic logic [5:0] pexp(input logic [7:0] c, input logic [8:0] x);
      logic e, i, pd, pc, di, rw, rr, ma, da;
      {e, i, pd, pc, di, rw, rr, ma, da} = x;
      if (e) return 6'h00;
      return {c[7] & (pd | pc & di), c[6] & pd, c[4] & (rw | ma & pd), c[3] & ma & pd | rr & ~ma, c[1] & da & pd,
         c[0] & da & pd};
   endfunction : pexp
   // -------------------------------------------------------------
   // result watcher: settled values only, away from the driving edge
   // -------------------------------------------------------------
   always @(negedge clock) begin
      if (wbAck && !wbWe) chk(wbDatR, rq.pop_front());
      if (capV) chk(32'(capD), 32'(dq.pop_front()));
      if (capV) chk(32'(dmaDataOe), 32'h1);
      if (rxValid) chk(32'(rxData), 32'(dq.pop_front()));
   end
   initial begin
      logic [7:0] v, cfg;
      logic [8:0] ctx;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      rd(aLen, '0);
      rd(aPar, '0);
      rd(aMask, '0);
      rd(aDma, '0);
      rd(aStat, '0);
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         wb(1'b1, aLen, {24'($random(seed)), v});
         rd(aLen, {24'h0, v});
         chk(32'({group7Bytes, group6Bytes}), {22'h0, v[7:4], 1'b0, v[3:0], 1'b0});
         wb(1'b1, aDma, {24'h0, v & 8'hEF});
         rd(aDma, {24'h0, v & 8'hEF});
         chk(32'(dmaWide), 32'(v[5]));
         wb(1'b1, aFree, {24'h0, v});
         rd(aFree, '0);
      end
      // settings written but not applied must stay inert
      wb(1'b1, aPar, 32'hFF);
      {extAccess, initiator, phaseData, phaseCtl, dirIn, mpuRegWrite, mpuRegRead, mpuDataAccess, dmaAccess}
         <= 9'h03D;
      repeat (3) @(posedge clock);
      chk(32'({scsiChkEn, mpuChkEn, dmaChkEn}), '0);
      for (int i = 0; i < 12; i++) begin
         cfg = 8'($random(seed));
         if (cfg[7]) {cfg[3], cfg[0]} = 2'h3;
         wb(1'b1, aPar, {24'h0, cfg});
         wb(1'b1, aCtl, 32'h1);
         repeat (4) begin
            ctx = 9'($random(seed));
            @(posedge clock);
            {extAccess, initiator, phaseData, phaseCtl, dirIn, mpuRegWrite, mpuRegRead, mpuDataAccess, dmaAccess}
               <= ctx;
            repeat (2) @(posedge clock);
            chk(32'(parEn), 32'(pexp(cfg, ctx)));
            chk(32'(oddParity), 32'(cfg[5]));
         end
      end
      wb(1'b1, aPar, {24'h0, ~cfg});
      repeat (2) @(posedge clock);
      chk(32'(parEn), 32'(pexp(cfg, ctx)));
      for (int g = 0; g < 16; g++) begin
         v = 8'($random(seed));
         if (g < 8) v[7] = 1'b1;
         wb(1'b1, aMask, {24'h0, v});
         cfg = {g[2:0], 5'($random(seed))};
         @(posedge clock);
         {intCode, intCodeValid} <= {cfg, 1'b1};
         @(posedge clock);
         intCodeValid <= 1'b0;
         repeat (3) @(posedge clock);
         chk(32'(intOut), 32'(v[7] && g[2:0] < 3'h6 && v[g[2:0]]));
         rd(aStat, {24'h0, cfg});
         repeat (3) @(posedge clock);
         chk(32'(intOut), '0);
      end
      partEn <= 1'b1;
      repeat (6) dmaWord(1'b1);
      repeat (6) dmaWord(1'b0);
      @(posedge clock);
      partEn <= 1'b0;
      wb(1'b1, aDma, 32'h10);
      repeat (30) begin
         @(posedge clock);
         xferPossible <= 1'($random(seed));
      end
      @(posedge clock);
      xferPossible <= 1'b0;
      repeat (4) @(posedge clock);
      wrap_up();
   end
endmodule : scsi_setup_regs_test
bind scsi_setup_regs scsi_setup_regs_properties scsi_setup_regs_properties_i (.clock, .sys_rst, .wbCyc, .wbStb,
   .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck, .extAccess, .phaseData, .xferPossible, .transfer_grant_in,
   .transfer_request_out, .intOut, .scsiChkEn, .scsiGenEn, .mpuChkEn, .mpuGenEn, .dmaChkEn, .dmaGenEn,
   .group6Bytes, .group7Bytes);
`default_nettype wire
